// ### design/pmc_host.sv
// host side sequencer that loads the mode register of a pseudo-static
// ram and drives its deep sleep entry and exit over the pins
// assumes software on SYS_CLK and a device wired straight to the pins
`timescale 1ns/10ps
`include "pmc_defs.svh"

////////////////////////////////////////////////////////////////////////
module pmc_host
	import pmc_pkg::*;
#(
	parameter int ADDR_W      = 22,
	parameter int TIMER_W     = 16,
	parameter int WC_CYC      = `PMC_WC_CYC,
	parameter int ZZMIN_CYC   = `PMC_ZZMIN_CYC,
	parameter int RECOVER_CYC = `PMC_RECOVER_CYC
) (
	// clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RST_N,
	// software register port
	input  wire logic [7:0]        REG_ADDR,
	input  wire logic [31:0]       REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [31:0]       REG_RDATA,
	// access permission check for the normal access path
	input  wire logic [ADDR_W-1:0] ACC_ADDR,
	output logic                   ACC_PERMIT,
	// device pins
	output logic                   PSRAM_CE_N,
	output logic                   PSRAM_WE_N,
	output logic                   PSRAM_OE_N,
	output logic                   PSRAM_UPPER_BYTE_N,
	output logic                   PSRAM_LOWER_BYTE_N,
	output logic                   PSRAM_SLEEP_N,
	output logic      [ADDR_W-1:0] PSRAM_ADDR
);

	////////////////////////////////////////////////////////////////////
	// declarations

	pmc_state_e          state_q;     // sequencer state
	pmc_state_e          state_d;     // its next value
	pmc_op_e             op_q;        // operation in progress
	logic [ADDR_W-1:0]   mode_q;      // mode word to be loaded
	logic [ADDR_W-1:0]   loaded_q;    // last mode word loaded
	logic                wake_q;      // wake request pending
	logic                reduced_q;   // reduced size in force
	logic [31:0]         rdata_q;     // read data register
	logic                timer_load;  // restart delay on state change
	logic [TIMER_W-1:0]  timer_val;   // delay for the state entered
	logic                expired;     // current delay has elapsed
	logic                cmd_load;    // load command strobe
	logic                cmd_sleep;   // sleep command strobe
	logic                cmd_wake;    // wake command strobe
	logic [1:0]          top_bits;    // top address bits under check
	logic                in_region;   // address inside reduced region

	// command strobes from the control register
	assign cmd_load  = REG_WR && (REG_ADDR == `PMC_REG_CTRL)
		&& REG_WDATA[`PMC_CMD_LOAD];
	assign cmd_sleep = REG_WR && (REG_ADDR == `PMC_REG_CTRL)
		&& REG_WDATA[`PMC_CMD_SLEEP];
	assign cmd_wake  = REG_WR && (REG_ADDR == `PMC_REG_CTRL)
		&& REG_WDATA[`PMC_CMD_WAKE];

	////////////////////////////////////////////////////////////////////
	// delay timer

	// every state restarts the timer with its own least delay
	assign timer_load = (state_d != state_q);

	// delay picked by the state being entered
	always_comb begin
		case (state_d)
			PMC_DESEL:   timer_val = TIMER_W'(`PMC_CDZZ_CYC);
			PMC_ZZ_WE:   timer_val = TIMER_W'(`PMC_ZZWE_CYC);
			PMC_WRITE:   timer_val = TIMER_W'(WC_CYC);
			PMC_SLEEP:   timer_val = TIMER_W'(ZZMIN_CYC);
			PMC_RECOVER: timer_val = TIMER_W'(RECOVER_CYC);
			default:     timer_val = '0;
		endcase
	end

	pmc_timer #(
		.W (TIMER_W)
	) u_timer (
		.clk      (SYS_CLK),
		.rst_n    (RST_N),
		.load     (timer_load),
		.load_val (timer_val),
		.expired  (expired)
	);

	////////////////////////////////////////////////////////////////////
	// sequencer

	// next state; load and sleep commands are ignored unless idle, wake counts only in sleep
	always_comb begin
		state_d = state_q;
		case (state_q)
			PMC_IDLE: begin
				if (cmd_load || cmd_sleep) begin
					state_d = PMC_DESEL;
				end
			end
			PMC_DESEL: begin
				// chip stays deselected before sleep falls
				if (expired) begin
					state_d = (op_q == PMC_OP_SLEEP) ? PMC_SLEEP
						: PMC_ZZ_WE;
				end
			end
			PMC_ZZ_WE: begin
				// two cycles: inside the 10..500 ns window
				if (expired) begin
					state_d = PMC_WRITE;
				end
			end
			PMC_WRITE: begin
				if (expired) begin
					state_d = PMC_WR_END;
				end
			end
			PMC_WR_END: state_d = PMC_IDLE;
			PMC_SLEEP: begin
				// wake only after the least sleep pulse
				if (expired && wake_q) begin
					state_d = PMC_RECOVER;
				end
			end
			PMC_RECOVER: begin
				if (expired) begin
					state_d = PMC_IDLE;
				end
			end
			default: state_d = PMC_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= PMC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// operation latched when a command starts
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			op_q <= PMC_OP_LOAD;
		end else if (state_q == PMC_IDLE && cmd_sleep) begin
			op_q <= PMC_OP_SLEEP;
		end else if (state_q == PMC_IDLE && cmd_load) begin
			op_q <= PMC_OP_LOAD;
		end
	end

	// wake request held until the sleep state is left
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wake_q <= 1'b0;
		end else if (cmd_wake && state_q == PMC_SLEEP) begin
			wake_q <= 1'b1;
		end else if (state_q != PMC_SLEEP) begin
			wake_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode word state

	// pending mode word, writable only while idle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_q <= ADDR_W'(`PMC_MODE_RST);
		end else if (REG_WR && REG_ADDR == `PMC_REG_MODE
			&& state_q == PMC_IDLE) begin
			mode_q <= REG_WDATA[ADDR_W-1:0];
		end
	end

	// loaded word and reduced size follow a completed load only
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			loaded_q  <= ADDR_W'(`PMC_MODE_RST);
			reduced_q <= 1'b0;
		end else if (state_q == PMC_WR_END) begin
			loaded_q  <= mode_q;
			// takes effect one cycle after sleep rises, as idle returns; reset clears it, each later load recomputes it
			reduced_q <= mode_q[`PMC_MW_PARTIAL]
				&& mode_q[`PMC_MW_REDUCED];
		end
	end

	////////////////////////////////////////////////////////////////////
	// pins; strobes registered from the next state, address from the load command

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PSRAM_CE_N    <= 1'b1;
			PSRAM_WE_N    <= 1'b1;
			PSRAM_SLEEP_N <= 1'b1;
			PSRAM_ADDR    <= '0;
		end else begin
			// chip enabled only for the register write
			PSRAM_CE_N    <= (state_d != PMC_WRITE);
			PSRAM_WE_N    <= (state_d != PMC_WRITE);
			// sleep low through the write and the sleep period
			PSRAM_SLEEP_N <= !(state_d == PMC_ZZ_WE
				|| state_d == PMC_WRITE
				|| state_d == PMC_SLEEP);
			// mode word set up at the load command, held to the next
			if (state_q == PMC_IDLE && cmd_load) begin
				PSRAM_ADDR <= mode_q;
			end
		end
	end

	// reads are not used by this block
	assign PSRAM_OE_N         = 1'b1;
	assign PSRAM_UPPER_BYTE_N = 1'b1;
	assign PSRAM_LOWER_BYTE_N = 1'b1;

	////////////////////////////////////////////////////////////////////
	// access permission

	// top two address bits of the 32Mb die split it into quarters
	assign top_bits = ACC_ADDR[`PMC_RMS_MSB -: 2];

	// region test against the loaded region code
	always_comb begin
		case (loaded_q[`PMC_MW_REGION_LSB +: 3])
			`PMC_RG_LO_QUARTER: in_region = (top_bits == 2'h0);
			`PMC_RG_LO_HALF:    in_region = !top_bits[1];
			`PMC_RG_HI_QUARTER: in_region = (top_bits == 2'h3);
			`PMC_RG_HI_HALF:    in_region = top_bits[1];
			default:            in_region = 1'b1;
		endcase
	end

	// normal accesses only when idle and, with reduced size in force, inside the region
	assign ACC_PERMIT = (state_q == PMC_IDLE)
		&& (!reduced_q || in_region);

	////////////////////////////////////////////////////////////////////
	// register read port

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= 32'h0000_0000;
		end else if (REG_RD) begin
			rdata_q <= 32'h0000_0000;
			case (REG_ADDR)
				`PMC_REG_MODE: rdata_q[ADDR_W-1:0] <= mode_q;
				`PMC_REG_LOADED: begin
					rdata_q[ADDR_W-1:0] <= loaded_q;
				end
				`PMC_REG_STATUS: begin
					rdata_q[`PMC_ST_BUSY]    <= (state_q != PMC_IDLE);
					rdata_q[`PMC_ST_SLEEP]   <= (state_q == PMC_SLEEP);
					rdata_q[`PMC_ST_RECOVER] <= (state_q == PMC_RECOVER);
					rdata_q[`PMC_ST_PARTIAL] <=
						loaded_q[`PMC_MW_PARTIAL];
					rdata_q[`PMC_ST_PAGE]    <=
						loaded_q[`PMC_MW_PAGE];
					rdata_q[`PMC_ST_REDUCED] <= reduced_q;
				end
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	assign REG_RDATA = rdata_q;

endmodule

// ### design/pmc_defs.svh
// offsets, field positions, reset values and timing counts of the
// power mode controller; assumes a 10 ns system clock
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// system clock period in ns
`define PMC_CLK_NS          10
// software register indices
`define PMC_REG_CTRL        8'h00
`define PMC_REG_MODE        8'h01
`define PMC_REG_STATUS      8'h02
`define PMC_REG_LOADED      8'h03
// control register command bits (write only, self clearing)
`define PMC_CMD_LOAD        0
`define PMC_CMD_SLEEP       1
`define PMC_CMD_WAKE        2
// mode word fields as driven on the address lines
`define PMC_MW_REGION_LSB   0
`define PMC_MW_REDUCED      3
`define PMC_MW_PARTIAL      4
`define PMC_MW_TEMP_LSB     5
`define PMC_MW_PAGE         7
// status register bits
`define PMC_ST_BUSY         0
`define PMC_ST_SLEEP        1
`define PMC_ST_RECOVER      2
`define PMC_ST_PARTIAL      3
`define PMC_ST_PAGE         4
`define PMC_ST_REDUCED      5
// reset value of the pending mode word
`define PMC_MODE_RST        22'h000000
// region codes for reduced size on the 32Mb die
`define PMC_RG_LO_QUARTER   3'h3
`define PMC_RG_LO_HALF      3'h2
`define PMC_RG_HI_QUARTER   3'h7
`define PMC_RG_HI_HALF      3'h6
// top address bit of the 32Mb die; it and the bit below pick the quarter
`define PMC_RMS_MSB         20
// times as printed, ns
`define PMC_T_CDZZ_NS       5
`define PMC_T_ZZWE_MIN_NS   10
`define PMC_T_ZZWE_MAX_NS   500
`define PMC_T_WC_NS         85
`define PMC_T_ZZMIN_NS      10000
`define PMC_T_RECOVER_NS    200000
// derived cycle counts, least times rounded up
`define PMC_CYC(ns)         (((ns) + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_CDZZ_CYC        `PMC_CYC(`PMC_T_CDZZ_NS)
`define PMC_ZZWE_CYC        `PMC_CYC(`PMC_T_ZZWE_MIN_NS)
`define PMC_WC_CYC          `PMC_CYC(`PMC_T_WC_NS)
`define PMC_ZZMIN_CYC       `PMC_CYC(`PMC_T_ZZMIN_NS)
`define PMC_RECOVER_CYC     `PMC_CYC(`PMC_T_RECOVER_NS)

`endif

// ### design/pmc_pkg.sv
// types shared by the power mode controller
// assumes nothing of its surroundings
package pmc_pkg;

	// sequencer states
	typedef enum logic [2:0] {
		PMC_IDLE    = 3'b000,
		PMC_DESEL   = 3'b001,
		PMC_ZZ_WE   = 3'b010,
		PMC_WRITE   = 3'b011,
		PMC_WR_END  = 3'b100,
		PMC_SLEEP   = 3'b101,
		PMC_RECOVER = 3'b110
	} pmc_state_e;

	// operation being run
	typedef enum logic {
		PMC_OP_LOAD  = 1'b0,
		PMC_OP_SLEEP = 1'b1
	} pmc_op_e;

endpackage

// ### design/pmc_timer.sv
// down counter used for every pin-to-pin delay of the sequencer
// assumes a load pulse from logic on the same clock
`timescale 1ns/10ps

module pmc_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// load and status
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expired
);

	logic [W-1:0] count_q;  // cycles still to wait

	// load wins over counting down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= load_val;
		end else if (count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	// zero means the delay has run out
	assign expired = (count_q == '0);

endmodule

// ### test/pmc_properties.sv
// checker of the pin sequence of the power mode controller
// assumes it is bound into the controller and sees its ports only
`timescale 1ns/10ps

module pmc_properties #(
	parameter int ADDR_W = 22
) (
	// clock and reset
	input wire logic              SYS_CLK,
	input wire logic              RST_N,
	// register read port
	input wire logic              REG_RD,
	input wire logic [31:0]       REG_RDATA,
	// access check
	input wire logic              ACC_PERMIT,
	// device pins
	input wire logic              PSRAM_CE_N,
	input wire logic              PSRAM_WE_N,
	input wire logic              PSRAM_SLEEP_N,
	input wire logic [ADDR_W-1:0] PSRAM_ADDR
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////////////
	// write pulse held low for the whole register cycle
	sequence wr_held;
		(!PSRAM_WE_N)[*8] ##1 !PSRAM_WE_N;
	endsequence
	////////////////////////////////////////////////////////////////////
	desel_lead_a: assert property (
		$fell(PSRAM_SLEEP_N) |-> PSRAM_CE_N && $past(PSRAM_CE_N))
		else $error("sleep fell without deselect lead");
	sleep_to_we_a: assert property (
		$fell(PSRAM_WE_N) |->
		!$past(PSRAM_SLEEP_N, 2) && $past(PSRAM_SLEEP_N, 3))
		else $error("write fell at wrong distance from sleep");
	write_width_a: assert property (
		$fell(PSRAM_WE_N) |-> wr_held ##[1:3] PSRAM_WE_N)
		else $error("register write cycle wrong length");
	mode_stable_a: assert property (
		!PSRAM_WE_N && !$past(PSRAM_WE_N) |-> $stable(PSRAM_ADDR))
		else $error("mode word moved during write");
	write_frame_a: assert property (
		!PSRAM_WE_N |-> !PSRAM_CE_N && !PSRAM_SLEEP_N)
		else $error("write outside sleep frame");
	sleep_min_a: assert property (
		$fell(PSRAM_SLEEP_N) |-> (!PSRAM_SLEEP_N)[*8])
		else $error("sleep pulse too short");
	sleep_block_a: assert property (
		!PSRAM_SLEEP_N |-> !ACC_PERMIT)
		else $error("access permitted while asleep");
	desel_idle_a: assert property (
		!PSRAM_SLEEP_N && PSRAM_WE_N |-> PSRAM_CE_N)
		else $error("chip selected in sleep without write");
	rdata_idle_a: assert property (
		!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside read answer");
endmodule

// ### test/pmc_dev_model.sv
// behavioural model of the ram power modes and mode register
// assumes pins driven by the controller; counts timing slips
`timescale 1ns/10ps

module pmc_dev_model (
	// device pins
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        sleep_n,
	input  wire logic [21:0] addr,
	// state seen inside the device
	output logic      [21:0] mode_q = 22'h000000,
	output logic             deep_q = 1'b0,
	output logic             partial_q = 1'b0,
	output logic      [7:0]  viol_q = 8'h00
);
	realtime t_ce = 0.0; // last deselect
	realtime t_zz = 0.0; // last sleep fall
	realtime t_we = 0.0; // last write fall
	logic    arm = 1'b0; // write began in sleep
	////////////////////////////////////////////////////////////////////
	// deselect stamp
	always @(posedge ce_n) t_ce = $realtime;
	// sleep entry needs a deselected chip
	always @(negedge sleep_n) begin
		t_zz = $realtime;
		if (!ce_n || $realtime - t_ce < 5.0) viol_q++;
	end
	// write must fall inside the window after sleep
	always @(negedge we_n) begin
		t_we = $realtime;
		arm = !sleep_n;
		if (sleep_n || $realtime - t_zz < 10.0 || $realtime - t_zz > 500.0)
			viol_q++;
	end
	// write end latches the mode word
	always @(posedge we_n) if (arm) begin
		if ($realtime - t_we < 85.0) viol_q++;
		mode_q = addr;
		arm = 1'b0;
	end
	// low-power state after the entry delay, full refresh once awake
	always #100.0 begin
		deep_q = !sleep_n && $realtime - t_zz >= 10000.0 && !mode_q[4];
		partial_q = !sleep_n && $realtime - t_zz >= 10000.0 && mode_q[4];
	end
endmodule

// ### test/tb_top.sv
// testbench: controller, device model and bound checker
// assumes the design files are compiled first
`timescale 1ns/10ps
`include "pmc_defs.svh"

module tb_top;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [21:0] acc_addr = 22'h0;
	logic [31:0] reg_rdata, rd_q;
	logic        acc_permit, ce_n, we_n, oe_n, ub_n, lb_n, sleep_n;
	logic [21:0] mem_addr, dev_mode;
	logic        dev_deep, dev_partial;
	logic [7:0]  dev_viol;
	int          num_errors = 0;
	int          samples_checked = 0;
	////////////////////////////////////////////////////////////////////
	always #5 sys_clk = ~sys_clk;
	task automatic check(input logic [31:0] got, exp, input string s);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h", $time, s, got);
		end
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		rd_q = reg_rdata;
	endtask
	// poll status until not busy, bounded
	task automatic wait_idle;
		int n = 0;
		rd_q = 32'h1;
		while (rd_q[`PMC_ST_BUSY] !== 1'b0) begin
			reg_read(`PMC_REG_STATUS);
			n++;
			if (n > 100) begin
				check(1'b0, 1'b1, "busy stuck");
				give_verdict;
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check({ce_n, we_n, oe_n, ub_n, lb_n, sleep_n, mem_addr}, 28'hfc00000,
			"idle pins");
		reg_read(`PMC_REG_STATUS);
		check(rd_q, 32'h0, "status");
		reg_write(8'h09, 32'h5);
		reg_read(8'h09);
		check(rd_q, 32'h0, "unmapped");
	endtask
	// load, with a refused mode write while busy
	task automatic t_load(input logic [21:0] w);
		reg_write(`PMC_REG_MODE, {10'h0, w});
		reg_write(`PMC_REG_CTRL, 32'h1);
		reg_write(`PMC_REG_MODE, {10'h0, ~w});
		wait_idle;
		check(rd_q[5:3], {w[4] & w[3], w[7], w[4]}, "status");
		check(dev_mode, w, "device mode");
		check(dev_viol, 8'h0, "pin timing");
		reg_read(`PMC_REG_LOADED);
		check(rd_q, {10'h0, w}, "loaded");
		reg_read(`PMC_REG_MODE);
		check(rd_q, {10'h0, w}, "mode kept");
	endtask
	// reduced size, low quarter: only the bottom quarter is open
	task automatic t_access;
		logic [21:0] a [4] = '{22'h0, 22'h07ffff, 22'h080000, 22'h1fffff};
		t_load(22'h00001b);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			acc_addr <= a[i];
			@(negedge sys_clk);
			check(acc_permit, i < 2, "permit");
		end
	endtask
	task automatic t_sleep(input logic [21:0] w);
		t_load(w);
		reg_write(`PMC_REG_CTRL, 32'h2);
		repeat (1200) @(posedge sys_clk);
		reg_read(`PMC_REG_STATUS);
		check({rd_q[1], sleep_n, acc_permit}, 3'b100, "asleep");
		check({dev_deep, dev_partial}, {~w[4], w[4]}, "mode");
		reg_write(`PMC_REG_CTRL, 32'h4);
		reg_read(`PMC_REG_STATUS);
		check({rd_q[2], acc_permit}, 2'b10, "recovering");
		wait_idle;
		repeat (20) @(posedge sys_clk);
		check({sleep_n, dev_deep, dev_partial}, 3'b100, "woken");
	endtask
	// wake asked for at once is held off for the least sleep pulse
	task automatic t_early_wake;
		reg_write(`PMC_REG_CTRL, 32'h2);
		repeat (4) @(posedge sys_clk);
		reg_write(`PMC_REG_CTRL, 32'h4);
		repeat (990) @(negedge sys_clk);
		check(sleep_n, 1'b0, "early wake");
		wait_idle;
		check(sleep_n, 1'b1, "late wake");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_load(22'h000080);
		t_load(22'h000017);
		t_load(22'h000060);
		t_access;
		t_sleep(22'h000000);
		t_early_wake;
		t_sleep(22'h000012);
		give_verdict;
	end
	pmc_host #(
		.RECOVER_CYC (8)
	) pmc_host_i (
		.SYS_CLK            (sys_clk),
		.RST_N              (rst_n),
		.REG_ADDR           (reg_addr),
		.REG_WDATA          (reg_wdata),
		.REG_WR             (reg_wr),
		.REG_RD             (reg_rd),
		.REG_RDATA          (reg_rdata),
		.ACC_ADDR           (acc_addr),
		.ACC_PERMIT         (acc_permit),
		.PSRAM_CE_N         (ce_n),
		.PSRAM_WE_N         (we_n),
		.PSRAM_OE_N         (oe_n),
		.PSRAM_UPPER_BYTE_N (ub_n),
		.PSRAM_LOWER_BYTE_N (lb_n),
		.PSRAM_SLEEP_N      (sleep_n),
		.PSRAM_ADDR         (mem_addr)
	);
	pmc_dev_model pmc_dev_model_i (
		.ce_n      (ce_n),
		.we_n      (we_n),
		.sleep_n   (sleep_n),
		.addr      (mem_addr),
		.mode_q    (dev_mode),
		.deep_q    (dev_deep),
		.partial_q (dev_partial),
		.viol_q    (dev_viol)
	);
endmodule

bind pmc_host pmc_properties #(.ADDR_W(ADDR_W)) pmc_properties_i (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .ACC_PERMIT(ACC_PERMIT),
	.PSRAM_CE_N(PSRAM_CE_N), .PSRAM_WE_N(PSRAM_WE_N),
	.PSRAM_SLEEP_N(PSRAM_SLEEP_N), .PSRAM_ADDR(PSRAM_ADDR)
);
